// ---- design/gate_regs.svh ----
// Functional notes
// [R1] Probe, identity, temperature, package config commands serviced in every sleep state.
// [R2] Core register read to a core in C3 or deeper answers 0x82.
// [R3] Local and space config accesses answer 0x82 when resources sleep.
// [R4] Wake bit set raises package to C2 so config access completes.
// [R5] In S0 and S1 probe, identity, temperature, package and local config serviced.
// [R6] Space config and core register reads guaranteed in S0 only.
// [R7] Reset fully resets client; warm reset returns link idle, defaults restored.
// [R8] Thermal filter constant and socket number survive warm reset.
// [R9] Temperature reading forced to 0x0000 on warm reset.
// [R10] Reset assertion aborts a transaction by ceasing response drive.
// [R11] While reset sequence runs, commands needing reset resources get unavailable answer.
// [R12] Boot mode serves only probe, local config, package read index 0; code also serves identity and temperature.
// [R13] Socket stays in boot mode until the go handshake arrives.
// [R14] Non power-unit catastrophic error still serves probe, identity, temp, package config.
// [R15] Power-unit catastrophic error answers 0x91; only probe, temp, identity served.
// [R16] In error condition unavailable services answer a timeout code.
// [R17] Originator debugs an error by package read index 0 parameter 5.
// [R18] After a pass in error, originator probes each command in turn.
// [R19] Repeated 0x81 answers leave only probe, temp, identity as guaranteed.
// [R20] Completion code bit 7 set on failure, clear on pass.
// [R21] Code 0x81 means resources could not be allocated; retry allowed.
// [R22] Decision is combinational on inputs and registered before the response.
`ifndef GATE_REGS_SVH
`define GATE_REGS_SVH
`define CC_PASS 8'h40
`define CC_TIMEOUT 8'h81
`define CC_LOW_POWER 8'h82
`define CC_ILLEGAL 8'h90
`define CC_CTRL_ERROR 8'h91
`define CC_FAIL_BIT 7
`define TEMP_WARM_VALUE 16'h0000
`define CORE_DEEP_SLEEP 3'h3
`define PKG_WAKE_STATE 3'h2
`define SYS_S0 3'h0
`define SYS_S1 3'h1
`define PKG_READ_BOOT_INDEX 8'h00
`define REG_CONTROL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_TEMP 32'h0000_0008
`define REG_FILTER 32'h0000_000C
`define CTRL_WAKE_BIT 0
`define CTRL_GO_BIT 1
`define FILTER_RESET 8'h00
`endif

// ---- design/gate_pkg.sv ----
package gate_pkg;
    typedef enum logic [3:0] {
        CMD_PROBE, CMD_IDENTITY, CMD_TEMP, CMD_PKG_READ, CMD_PKG_WRITE,
        CMD_CORE_READ, CMD_LOCAL_READ, CMD_LOCAL_WRITE, CMD_SPACE_READ, CMD_OTHER
    } cmd_e;
    typedef enum logic [1:0] {ACT_SERVE, ACT_CODE, ACT_SILENT} act_e;
endpackage : gate_pkg

// ---- design/gate_decide.sv ----
`timescale 1ns/100ps
`include "gate_regs.svh"
module gate_decide
    import gate_pkg::*;
(
    input wire cmd_e cmd_i,
    input wire logic [7:0] index_i,
    input wire logic core_deep_i,
    input wire logic res_low_i,
    input wire logic wake_i,
    input wire logic [2:0] sys_state_i,
    input wire logic boot_mode_i,
    input wire logic rst_busy_i,
    input wire logic err_i,
    input wire logic err_pcu_i,
    output act_e act_o,
    output logic [7:0] code_o,
    output logic wake_req_o
);
    function automatic logic is_basic(input cmd_e c);
        return c == CMD_PROBE || c == CMD_IDENTITY || c == CMD_TEMP;
    endfunction
    function automatic logic is_cfg(input cmd_e c);
        return c == CMD_LOCAL_READ || c == CMD_LOCAL_WRITE || c == CMD_SPACE_READ;
    endfunction
    // Priority runs from the most severe condition downward.
    always_comb begin
        act_o = ACT_SERVE;
        code_o = `CC_PASS;
        wake_req_o = 1'b0;
        if (cmd_i >= CMD_OTHER) begin
            act_o = ACT_CODE;
            code_o = `CC_ILLEGAL;
        end else if (is_basic(cmd_i)) begin
            act_o = ACT_SERVE; // [R1] [R5] [R14] [R15]
        end else if (err_i && err_pcu_i) begin
            act_o = ACT_CODE;
            code_o = `CC_CTRL_ERROR; // [R15]
        end else if (rst_busy_i) begin
            act_o = ACT_CODE;
            code_o = `CC_TIMEOUT; // [R11] [R21]
        end else if (boot_mode_i && !(is_cfg(cmd_i) && cmd_i != CMD_SPACE_READ)
                     && !(cmd_i == CMD_PKG_READ && index_i == `PKG_READ_BOOT_INDEX)) begin
            act_o = ACT_CODE;
            code_o = `CC_TIMEOUT; // [R12] [R13]
        end else if (err_i && (cmd_i == CMD_CORE_READ || cmd_i == CMD_SPACE_READ)) begin
            act_o = ACT_CODE;
            code_o = `CC_TIMEOUT; // [R16] [R14]
        end else if ((cmd_i == CMD_CORE_READ || cmd_i == CMD_SPACE_READ)
                     && sys_state_i != `SYS_S0) begin
            act_o = ACT_SILENT; // [R6]
        end else if (sys_state_i != `SYS_S0 && sys_state_i != `SYS_S1
                     && cmd_i != CMD_PKG_READ && cmd_i != CMD_PKG_WRITE) begin
            act_o = ACT_SILENT; // [R5]
        end else if (cmd_i == CMD_CORE_READ && core_deep_i) begin
            act_o = ACT_CODE;
            code_o = `CC_LOW_POWER; // [R2]
        end else if (is_cfg(cmd_i) && res_low_i) begin
            if (wake_i) begin
                wake_req_o = 1'b1; // [R4]
            end else begin
                act_o = ACT_CODE;
                code_o = `CC_LOW_POWER; // [R3]
            end
        end
    end
endmodule : gate_decide

// ---- design/sideband_cmd_availability_gate.sv ----
`timescale 1ns/100ps
`include "gate_regs.svh"
module sideband_cmd_availability_gate
    import gate_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [31:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [31:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic CMD_VALID_I,
    input wire logic [3:0] CMD_TYPE_I,
    input wire logic [7:0] CMD_INDEX_I,
    input wire logic [2:0] CORE_CSTATE_I,
    input wire logic RES_LOW_POWER_I,
    input wire logic [2:0] SYS_STATE_I,
    input wire logic BOOT_MODE_ENTER_I,
    input wire logic RESET_BUSY_I,
    input wire logic CAT_ERROR_I,
    input wire logic ERR_FROM_PCU_I,
    input wire logic [15:0] TEMP_I,
    input wire logic TEMP_VALID_I,
    input wire logic [1:0] SOCKET_STRAP_I,
    input wire logic WARM_RESET_I,
    output logic RSP_VALID_O,
    output logic [1:0] RSP_ACTION_O,
    output logic [7:0] RSP_CODE_O,
    output logic RSP_DRIVE_O,
    output logic PKG_WAKE_O,
    output logic [2:0] PKG_WAKE_STATE_O,
    output logic BOOT_MODE_O
);
    act_e act;
    logic [7:0] code;
    logic wake_req;
    logic [2:0] err_sync_q;
    logic [2:0] boot_sync_q;
    logic [2:0] warm_sync_q;
    logic err_q;
    logic warm_q;
    logic warm_prev_q;
    logic warm_fall;
    logic wake_bit_q;
    logic boot_q;
    logic [7:0] filter_q;
    logic [1:0] socket_q;
    logic socket_cap_q;
    logic [15:0] temp_q;
    logic aw_got_q;
    logic w_got_q;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Three stages; a change counts only once the last two agree.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            err_sync_q <= 3'h0;
            boot_sync_q <= 3'h0;
            warm_sync_q <= 3'h0;
            err_q <= 1'b0;
            warm_q <= 1'b0;
        end else begin
            err_sync_q <= {err_sync_q[1:0], CAT_ERROR_I};
            boot_sync_q <= {boot_sync_q[1:0], BOOT_MODE_ENTER_I};
            warm_sync_q <= {warm_sync_q[1:0], WARM_RESET_I};
            if (err_sync_q[1] == err_sync_q[2]) begin
                err_q <= err_sync_q[2];
            end
            if (warm_sync_q[1] == warm_sync_q[2]) begin
                warm_q <= warm_sync_q[2];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            warm_prev_q <= 1'b0;
        end else begin
            warm_prev_q <= warm_q;
        end
    end
    assign warm_fall = warm_prev_q && !warm_q;

    gate_decide u_decide (
        .cmd_i(cmd_e'(CMD_TYPE_I)),
        .index_i(CMD_INDEX_I),
        .core_deep_i(CORE_CSTATE_I >= `CORE_DEEP_SLEEP),
        .res_low_i(RES_LOW_POWER_I),
        .wake_i(wake_bit_q),
        .sys_state_i(SYS_STATE_I),
        .boot_mode_i(boot_q),
        .rst_busy_i(RESET_BUSY_I || warm_q),
        .err_i(err_q),
        .err_pcu_i(ERR_FROM_PCU_I),
        .act_o(act),
        .code_o(code),
        .wake_req_o(wake_req)
    );

    // The answer is held in flops so the link never sees a half-settled decision.
    always_ff @(posedge CLK_I) begin
        if (RST_I || warm_q) begin
            RSP_VALID_O <= 1'b0; // [R7] [R10]
            RSP_ACTION_O <= ACT_SILENT;
            RSP_CODE_O <= `CC_PASS;
            RSP_DRIVE_O <= 1'b0; // [R10]
        end else begin
            RSP_VALID_O <= CMD_VALID_I; // [R22]
            if (CMD_VALID_I) begin
                RSP_ACTION_O <= act;
                RSP_CODE_O <= code; // [R20]
                RSP_DRIVE_O <= act != ACT_SILENT;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || warm_q) begin
            PKG_WAKE_O <= 1'b0;
        end else begin
            PKG_WAKE_O <= CMD_VALID_I && wake_req; // [R4]
        end
    end
    always_ff @(posedge CLK_I) begin
        PKG_WAKE_STATE_O <= `PKG_WAKE_STATE; // [R4]
    end

    // Boot mode is left only through the go write from the originator or a cold reset.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            boot_q <= 1'b0;
        end else if (boot_sync_q[1] && boot_sync_q[2]) begin
            boot_q <= 1'b1;
        end else if (aw_got_q && w_got_q && aw_addr_q == `REG_CONTROL
                     && w_data_q[`CTRL_GO_BIT]) begin
            boot_q <= 1'b0; // [R13]
        end
    end
    assign BOOT_MODE_O = boot_q;

    // Socket strap is caught once after release and never recaptured on warm reset.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            socket_q <= 2'h0;
            socket_cap_q <= 1'b0;
        end else if (!socket_cap_q) begin
            socket_q <= SOCKET_STRAP_I; // [R8]
            socket_cap_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || warm_fall) begin
            temp_q <= `TEMP_WARM_VALUE; // [R9]
        end else if (TEMP_VALID_I && !warm_q) begin
            temp_q <= TEMP_I;
        end
    end

    // AXI4-Lite write side: address and data are taken in either order.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O <= 2'h0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O) begin
                w_got_q <= 1'b1;
                w_data_q <= WDATA_I;
                // The strobe is kept with its data, since the master may move on before the commit.
                w_strb_q <= WSTRB_I;
            end
            if (aw_got_q && w_got_q && !BVALID_O) begin
                BVALID_O <= 1'b1;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                BRESP_O <= (aw_addr_q == `REG_CONTROL || aw_addr_q == `REG_FILTER) ?
                    2'h0 : 2'h2;
            end else if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
            end
        end
    end
    assign AWREADY_O = !aw_got_q && !BVALID_O;
    assign WREADY_O = !w_got_q && !BVALID_O;

    // Wake bit returns to default on warm reset; filter constant survives it.
    always_ff @(posedge CLK_I) begin
        if (RST_I || warm_fall) begin
            wake_bit_q <= 1'b0; // [R7]
        end else if (aw_got_q && w_got_q && aw_addr_q == `REG_CONTROL && w_strb_q[0]) begin
            wake_bit_q <= w_data_q[`CTRL_WAKE_BIT];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            filter_q <= `FILTER_RESET;
        end else if (aw_got_q && w_got_q && aw_addr_q == `REG_FILTER) begin
            filter_q <= w_data_q[7:0]; // [R8]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h0000_0000;
            RRESP_O <= 2'h0;
        end else if (ARVALID_I && ARREADY_O) begin
            RVALID_O <= 1'b1;
            RRESP_O <= 2'h0;
            case (ARADDR_I)
                `REG_CONTROL: RDATA_O <= {30'h0, 1'b0, wake_bit_q};
                `REG_STATUS: RDATA_O <= {26'h0, socket_q, warm_q, err_q, boot_q, 1'b0};
                `REG_TEMP: RDATA_O <= {16'h0000, temp_q};
                `REG_FILTER: RDATA_O <= {24'h00_0000, filter_q};
                default: begin
                    RDATA_O <= 32'h0000_0000;
                    RRESP_O <= 2'h2;
                end
            endcase
        end else if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
        end
    end
    assign ARREADY_O = !RVALID_O;

    property p_pcu_code;
        @(posedge CLK_I) disable iff (RST_I)
        (CMD_VALID_I && !warm_q && err_q && ERR_FROM_PCU_I && CMD_TYPE_I == 4'h3 && !RESET_BUSY_I)
        |=> RSP_CODE_O == `CC_CTRL_ERROR;
    endproperty
    a_pcu_code: assert property (p_pcu_code) else $error("power unit error code wrong"); // [R15]
    property p_fail_bit;
        @(posedge CLK_I) disable iff (RST_I)
        RSP_VALID_O && RSP_ACTION_O == ACT_CODE |-> RSP_CODE_O[`CC_FAIL_BIT];
    endproperty
    a_fail_bit: assert property (p_fail_bit) else $error("fail bit clear on failure"); // [R20]
    property p_basic;
        @(posedge CLK_I) disable iff (RST_I)
        CMD_VALID_I && !warm_q && CMD_TYPE_I == 4'h0 |=> RSP_ACTION_O == ACT_SERVE;
    endproperty
    a_basic: assert property (p_basic) else $error("probe not served"); // [R1]
    property p_abort;
        @(posedge CLK_I) disable iff (RST_I)
        warm_q |=> !RSP_DRIVE_O && !RSP_VALID_O;
    endproperty
    a_abort: assert property (p_abort) else $error("response driven in reset"); // [R10]
    property p_temp;
        @(posedge CLK_I) disable iff (RST_I)
        warm_fall |=> temp_q == `TEMP_WARM_VALUE;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not cleared"); // [R9]
    property p_filter;
        @(posedge CLK_I) disable iff (RST_I)
        warm_fall |=> filter_q == $past(filter_q) && socket_q == $past(socket_q);
    endproperty
    a_filter: assert property (p_filter) else $error("kept state lost"); // [R8]
    property p_core;
        @(posedge CLK_I) disable iff (RST_I)
        CMD_VALID_I && !warm_q && !err_q && !boot_q && !RESET_BUSY_I && CMD_TYPE_I == 4'h5
        && SYS_STATE_I == `SYS_S0 && CORE_CSTATE_I >= `CORE_DEEP_SLEEP
        |=> RSP_CODE_O == `CC_LOW_POWER;
    endproperty
    a_core: assert property (p_core) else $error("deep core not refused"); // [R2]
    property p_busy;
        @(posedge CLK_I) disable iff (RST_I)
        CMD_VALID_I && !warm_q && RESET_BUSY_I && !err_q && CMD_TYPE_I == 4'h6
        |=> RSP_CODE_O == `CC_TIMEOUT;
    endproperty
    a_busy: assert property (p_busy) else $error("busy reset not refused"); // [R11]
    property p_pass_bit;
        @(posedge CLK_I) disable iff (RST_I)
        RSP_VALID_O && RSP_ACTION_O == ACT_SERVE |-> !RSP_CODE_O[`CC_FAIL_BIT];
    endproperty
    a_pass_bit: assert property (p_pass_bit) else $error("fail bit set on pass"); // [R20]
    property p_boot_refuse;
        @(posedge CLK_I) disable iff (RST_I)
        CMD_VALID_I && !warm_q && boot_q && !err_q && !RESET_BUSY_I && CMD_TYPE_I == 4'h5
        |=> RSP_CODE_O == `CC_TIMEOUT;
    endproperty
    a_boot_refuse: assert property (p_boot_refuse) else $error("boot not refused"); // [R12]
    property p_wake;
        @(posedge CLK_I) disable iff (RST_I)
        CMD_VALID_I && !warm_q && !err_q && !boot_q && !RESET_BUSY_I && wake_bit_q
        && RES_LOW_POWER_I && CMD_TYPE_I == 4'h7 && SYS_STATE_I == `SYS_S0
        |=> PKG_WAKE_O && RSP_ACTION_O == ACT_SERVE;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request missing"); // [R4]
    c_low_power: cover property (@(posedge CLK_I) disable iff (RST_I)
        RSP_VALID_O && RSP_CODE_O == `CC_LOW_POWER);
    c_wake: cover property (@(posedge CLK_I) disable iff (RST_I) PKG_WAKE_O);
    c_boot_exit: cover property (@(posedge CLK_I) disable iff (RST_I) $fell(boot_q));
    c_warm: cover property (@(posedge CLK_I) disable iff (RST_I) warm_fall);
endmodule : sideband_cmd_availability_gate

// ---- dv/cmd_originator.sv ----
`timescale 1ns/100ps
`include "gate_regs.svh"
module cmd_originator (
    input wire logic clk_i,
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_code_i,
    output logic cmd_valid_o,
    output logic [3:0] cmd_type_o,
    output logic [7:0] cmd_index_o,
    output logic basic_only_o
);
    logic [1:0] retry_q = 2'b00;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_type_o = 4'h0;
        cmd_index_o = 8'h00;
    end
    // Fields carry junk between commands, so a stale decode cannot pass unseen.
    task automatic issue(input logic [3:0] t, input logic [7:0] x);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_type_o <= t;
        cmd_index_o <= x;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_type_o <= ~t;
        cmd_index_o <= ~x;
        @(negedge clk_i);
    endtask : issue
    // Repeated timeouts leave only probe, identity and temperature trusted.
    always_ff @(posedge clk_i) begin
        if (rsp_valid_i) begin
            retry_q <= (rsp_code_i != `CC_TIMEOUT) ? 2'b00 : (retry_q == 2'b00 ? 2'b01 : 2'b10);
        end
    end
    assign basic_only_o = retry_q[1];
endmodule : cmd_originator

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`include "gate_regs.svh"
module tb_top
    import gate_pkg::*;
;
    logic CLK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, CMD_VALID_I;
    logic [31:0] AWADDR_I, WDATA_I, ARADDR_I, RDATA_O, rd;
    logic [3:0] WSTRB_I, CMD_TYPE_I;
    logic RES_LOW_POWER_I, BOOT_MODE_ENTER_I, RESET_BUSY_I, CAT_ERROR_I, ERR_FROM_PCU_I;
    logic TEMP_VALID_I, WARM_RESET_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
    logic RSP_VALID_O, RSP_DRIVE_O, PKG_WAKE_O, BOOT_MODE_O, basic_only;
    logic [1:0] BRESP_O, RRESP_O, RSP_ACTION_O, SOCKET_STRAP_I, rr, br;
    logic [7:0] CMD_INDEX_I, RSP_CODE_O;
    logic [2:0] CORE_CSTATE_I, SYS_STATE_I, PKG_WAKE_STATE_O;
    logic [15:0] TEMP_I;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    sideband_cmd_availability_gate sideband_cmd_availability_gate_inst (.*);
    cmd_originator cmd_originator_inst (
        .clk_i(CLK_I),
        .rsp_valid_i(RSP_VALID_O),
        .rsp_code_i(RSP_CODE_O),
        .cmd_valid_o(CMD_VALID_I),
        .cmd_type_o(CMD_TYPE_I),
        .cmd_index_o(CMD_INDEX_I),
        .basic_only_o(basic_only)
    );
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // The ceiling is dozens of times the length of the sequence below.
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge CLK_I);
        AWADDR_I <= a;
        WDATA_I <= d;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        BREADY_I <= 1'b1;
        while (!b_t) begin
            @(negedge CLK_I);
            aw_t = AWVALID_I & AWREADY_O;
            w_t = WVALID_I & WREADY_O;
            b_t = BVALID_O;
            br = BRESP_O;
            @(posedge CLK_I);
            if (aw_t) AWVALID_I <= 1'b0;
            if (w_t) WVALID_I <= 1'b0;
            if (b_t) BREADY_I <= 1'b0;
        end
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a);
        logic ar_t, got;
        got = 1'b0;
        @(posedge CLK_I);
        ARADDR_I <= a;
        ARVALID_I <= 1'b1;
        RREADY_I <= 1'b1;
        while (!got) begin
            @(negedge CLK_I);
            ar_t = ARVALID_I & ARREADY_O;
            got = RVALID_O;
            rd = RDATA_O;
            rr = RRESP_O;
            @(posedge CLK_I);
            if (ar_t) ARVALID_I <= 1'b0;
            if (got) RREADY_I <= 1'b0;
        end
    endtask : axi_read
    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        axi_read(a);
        check(n, rd, e);
    endtask : rchk
    task automatic cmd(input cmd_e t, input logic [7:0] x, input act_e a, input logic [7:0] c);
        cmd_originator_inst.issue(4'(t), x);
        check("rsp_valid", 32'(RSP_VALID_O), 32'h1);
        check("rsp_action", 32'(RSP_ACTION_O), 32'(a));
        if (a != ACT_SILENT) check("rsp_code", 32'(RSP_CODE_O), 32'(c));
    endtask : cmd
    // Status inputs are asynchronous to the gate, so each change settles for a few edges.
    task automatic env(input logic [2:0] cs, input logic lp, input logic [2:0] ss,
                       input logic bz, input logic ce, input logic pe);
        @(posedge CLK_I);
        CORE_CSTATE_I <= cs;
        RES_LOW_POWER_I <= lp;
        SYS_STATE_I <= ss;
        RESET_BUSY_I <= bz;
        CAT_ERROR_I <= ce;
        ERR_FROM_PCU_I <= pe;
        repeat (5) @(posedge CLK_I);
    endtask : env
    initial begin
        {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, TEMP_VALID_I} = '0;
        {AWADDR_I, WDATA_I, ARADDR_I, TEMP_I, CORE_CSTATE_I, SYS_STATE_I} = '0;
        {RES_LOW_POWER_I, BOOT_MODE_ENTER_I, RESET_BUSY_I, CAT_ERROR_I} = '0;
        {ERR_FROM_PCU_I, WARM_RESET_I} = '0;
        WSTRB_I = 4'hF;
        SOCKET_STRAP_I = 2'b10;
        RST_I = 1'b1;
        repeat (20) @(posedge CLK_I);
        RST_I <= 1'b0;
        rchk("control", `REG_CONTROL, 32'h0000_0000);
        rchk("filter", `REG_FILTER, 32'h0000_0000);
        rchk("status", `REG_STATUS, 32'h0000_0020);
        rchk("unmapped", 32'h0000_0010, 32'h0000_0000);
        check("unmapped_resp", 32'(rr), 32'h2);
        axi_write(`REG_STATUS, 32'h0000_0000);
        check("ro_bresp", 32'(br), 32'h2);
        $display("test registers done");
        for (int t = 0; t < 9; t++) begin
            cmd(cmd_e'(t), 8'h00, ACT_SERVE, `CC_PASS);
        end
        cmd(CMD_OTHER, 8'h00, ACT_CODE, `CC_ILLEGAL);
        cmd(cmd_e'(4'hB), 8'h00, ACT_CODE, `CC_ILLEGAL);
        $display("test command table done");
        env(3'h3, 1'b0, `SYS_S0, 1'b0, 1'b0, 1'b0);
        cmd(CMD_CORE_READ, 8'h00, ACT_CODE, `CC_LOW_POWER);
        cmd(CMD_PKG_READ, 8'h00, ACT_SERVE, `CC_PASS);
        env(3'h2, 1'b1, `SYS_S0, 1'b0, 1'b0, 1'b0);
        cmd(CMD_CORE_READ, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_LOCAL_READ, 8'h00, ACT_CODE, `CC_LOW_POWER);
        cmd(CMD_SPACE_READ, 8'h00, ACT_CODE, `CC_LOW_POWER);
        cmd(CMD_PKG_WRITE, 8'h00, ACT_SERVE, `CC_PASS);
        axi_write(`REG_CONTROL, 32'h0000_0001);
        check("ctrl_bresp", 32'(br), 32'h0);
        cmd(CMD_LOCAL_WRITE, 8'h00, ACT_SERVE, `CC_PASS);
        check("pkg_wake", 32'(PKG_WAKE_O), 32'h1);
        check("wake_state", 32'(PKG_WAKE_STATE_O), 32'(`PKG_WAKE_STATE));
        cmd(CMD_PKG_READ, 8'h00, ACT_SERVE, `CC_PASS);
        check("pkg_no_wake", 32'(PKG_WAKE_O), 32'h0);
        axi_write(`REG_CONTROL, 32'h0000_0000);
        $display("test sleep states done");
        env(3'h0, 1'b0, `SYS_S1, 1'b0, 1'b0, 1'b0);
        cmd(CMD_LOCAL_WRITE, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_SPACE_READ, 8'h00, ACT_SILENT, `CC_PASS);
        cmd(CMD_CORE_READ, 8'h00, ACT_SILENT, `CC_PASS);
        env(3'h0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0);
        cmd(CMD_PKG_READ, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_LOCAL_READ, 8'h00, ACT_SILENT, `CC_PASS);
        $display("test system states done");
        env(3'h0, 1'b0, `SYS_S0, 1'b0, 1'b1, 1'b0);
        // Debug of an error starts with a package read at index zero.
        cmd(CMD_PKG_READ, `PKG_READ_BOOT_INDEX, ACT_SERVE, `CC_PASS);
        cmd(CMD_LOCAL_READ, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_CORE_READ, 8'h00, ACT_CODE, `CC_TIMEOUT);
        env(3'h0, 1'b0, `SYS_S0, 1'b0, 1'b1, 1'b1);
        cmd(CMD_PKG_READ, 8'h00, ACT_CODE, `CC_CTRL_ERROR);
        cmd(CMD_TEMP, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_IDENTITY, 8'h00, ACT_SERVE, `CC_PASS);
        env(3'h0, 1'b0, `SYS_S0, 1'b1, 1'b0, 1'b0);
        cmd(CMD_PKG_READ, 8'h00, ACT_CODE, `CC_TIMEOUT);
        cmd(CMD_PKG_READ, 8'h00, ACT_CODE, `CC_TIMEOUT);
        @(negedge CLK_I);
        check("basic_only", 32'(basic_only), 32'h1);
        cmd(CMD_PROBE, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_LOCAL_READ, 8'h00, ACT_CODE, `CC_TIMEOUT);
        env(3'h0, 1'b0, `SYS_S0, 1'b0, 1'b0, 1'b0);
        $display("test errors done");
        BOOT_MODE_ENTER_I <= 1'b1;
        repeat (5) @(posedge CLK_I);
        BOOT_MODE_ENTER_I <= 1'b0;
        repeat (20) @(posedge CLK_I);
        check("boot_mode", 32'(BOOT_MODE_O), 32'h1);
        rchk("status_boot", `REG_STATUS, 32'h0000_0022);
        cmd(CMD_PKG_READ, `PKG_READ_BOOT_INDEX, ACT_SERVE, `CC_PASS);
        cmd(CMD_PKG_READ, 8'h01, ACT_CODE, `CC_TIMEOUT);
        cmd(CMD_LOCAL_WRITE, 8'h00, ACT_SERVE, `CC_PASS);
        cmd(CMD_CORE_READ, 8'h00, ACT_CODE, `CC_TIMEOUT);
        axi_write(`REG_CONTROL, 32'h0000_0002);
        repeat (2) @(posedge CLK_I);
        check("boot_left", 32'(BOOT_MODE_O), 32'h0);
        $display("test boot mode done");
        axi_write(`REG_FILTER, 32'h0000_005A);
        axi_write(`REG_CONTROL, 32'h0000_0001);
        @(posedge CLK_I);
        TEMP_I <= 16'h1234;
        TEMP_VALID_I <= 1'b1;
        @(posedge CLK_I);
        TEMP_VALID_I <= 1'b0;
        rchk("temp", `REG_TEMP, 32'h0000_1234);
        cmd(CMD_PROBE, 8'h00, ACT_SERVE, `CC_PASS);
        @(posedge CLK_I);
        WARM_RESET_I <= 1'b1;
        repeat (6) @(posedge CLK_I);
        #1;
        check("drive_abort", 32'(RSP_DRIVE_O), 32'h0);
        rchk("status_warm", `REG_STATUS, 32'h0000_0028);
        WARM_RESET_I <= 1'b0;
        repeat (6) @(posedge CLK_I);
        rchk("temp_warm", `REG_TEMP, 32'(`TEMP_WARM_VALUE));
        rchk("filter_kept", `REG_FILTER, 32'h0000_005A);
        rchk("socket_kept", `REG_STATUS, 32'h0000_0020);
        rchk("control_default", `REG_CONTROL, 32'h0000_0000);
        $display("test warm reset done");
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        rchk("filter_cold", `REG_FILTER, 32'(`FILTER_RESET));
        $display("test cold reset done");
        final_report();
    end
endmodule : tb_top
